// >>> scdb_pkg.sv
// Package for the system configuration bank: register map, reset values, carriers.
// Assumes a 32-bit Avalon-MM slave with byte addresses on the system clock.
package scdb_pkg;

  localparam int SCDB_ADDR_W = 8;
  localparam logic [7:0] SCDB_OFF_BYP_LO = 8'h0c;
  localparam logic [7:0] SCDB_OFF_BYP_HI = 8'h10;
  localparam logic [7:0] SCDB_OFF_DBG = 8'h14;
  localparam logic [7:0] SCDB_OFF_MEMPD = 8'h18;

  localparam int SCDB_NUM_LO = 30;
  localparam int SCDB_NUM_HI = 6;
  localparam int SCDB_NUM_MEM = 8;

  localparam logic [29:0] SCDB_RST_BYP_LO = 30'h00000000;
  localparam logic [5:0] SCDB_RST_BYP_HI = 6'h00;
  localparam logic [7:0] SCDB_RST_MEMPD = 8'h00;

  // Debug override field positions
  localparam int SCDB_DBG_C1_TAKE = 7;
  localparam int SCDB_DBG_C1_CLK = 6;
  localparam int SCDB_DBG_C1_DAT = 5;
  localparam int SCDB_DBG_C1_OBS = 4;
  localparam int SCDB_DBG_C0_TAKE = 3;
  localparam int SCDB_DBG_C0_CLK = 2;
  localparam int SCDB_DBG_C0_DAT = 1;
  localparam int SCDB_DBG_C0_OBS = 0;
  localparam logic SCDB_RST_TAKE = 1'b0;
  localparam logic SCDB_RST_DRIVE = 1'b1;

  // Memory power-down field positions
  localparam int SCDB_MEM_ROM = 7;
  localparam int SCDB_MEM_USB = 6;

  localparam int SCDB_SYNC_STAGES = 2;

  typedef struct packed {
    logic read;
    logic write;
    logic [SCDB_ADDR_W-1:0] address;
    logic [31:0] writedata;
  } scdb_avm_req_type;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } scdb_avm_rsp_type;

  // One core's debug port as seen by the core
  typedef struct packed {
    logic swclk;
    logic swdi;
  } scdb_dbg_drive_type;

endpackage : scdb_pkg

// >>> scdb_sync2.sv
// Two-flop synchroniser with a per-bit bypass that skips both flops.
// Assumes the asynchronous input comes straight from a pad.
module scdb_sync2
  import scdb_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] bypass,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } scdb_sync_state_type;

  scdb_sync_state_type st_q;
  scdb_sync_state_type st_d;

  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stab = st_q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Bypassed bits see the raw pad, two cycles earlier
  always_comb begin
    sync_out = (bypass & async_in) | (~bypass & st_q.stab);
  end

  a_bypass_direct: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sync_out == ((bypass & async_in) | (~bypass & $past(async_in, 2)))))
    else $error("synchroniser output wrong for bypass setting");

endmodule : scdb_sync2

// >>> scdb_sysconfig.sv
// System configuration bank: input synchroniser bypass, debug port override,
// memory power-down. Assumes an Avalon-MM master on clk_sys and pads
// outside the clock domain; the input register lies downstream.
//
// Function
// - Low bypass bits skip GPIO 0-29 synchronisers.
// - High bypass bits skip GPIO 30-35 synchronisers.
// - Bypassed inputs arrive two cycles sooner.
// - Bit 7 hands core 1 debug to registers.
// - Bit 3 hands core 0 debug to registers.
// - Bit 6 drives core 1 debug clock.
// - Bit 5 drives core 1 debug data.
// - Bit 4 reads core 1 debug output.
// - Bit 2 drives core 0 debug clock.
// - Bit 1 drives core 0 debug data.
// - Bit 0 reads core 0 debug output.
// - Power-down bits switch off ROM, USB, SRAMs.
//
// The Avalon-MM slave port was decided locally.
module scdb_sysconfig
  import scdb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire scdb_avm_req_type avm_req,
  output scdb_avm_rsp_type avm_rsp,
  input wire logic [SCDB_NUM_LO-1:0] gpio_lo_pad_in,
  input wire logic [SCDB_NUM_HI-1:0] gpio_hi_pad_in,
  output logic [SCDB_NUM_LO-1:0] gpio_lo_to_sio,
  output logic [SCDB_NUM_HI-1:0] gpio_hi_to_sio,
  input wire scdb_dbg_drive_type core0_pad_dbg,
  input wire scdb_dbg_drive_type core1_pad_dbg,
  output scdb_dbg_drive_type core0_dbg,
  output scdb_dbg_drive_type core1_dbg,
  input wire logic core0_swdo,
  input wire logic core1_swdo,
  output logic [SCDB_NUM_MEM-1:0] memory_power_down
);

  typedef struct packed {
    logic [SCDB_NUM_LO-1:0] byp_lo;
    logic [SCDB_NUM_HI-1:0] byp_hi;
    logic c1_take;
    logic c1_clk;
    logic c1_dat;
    logic c0_take;
    logic c0_clk;
    logic c0_dat;
    logic [SCDB_NUM_MEM-1:0] mempd;
    logic ack;
    logic [31:0] rdata;
  } scdb_state_type;

  scdb_state_type st_q;
  scdb_state_type st_d;
  logic [SCDB_NUM_LO-1:0] lo_sync;
  logic [SCDB_NUM_HI-1:0] hi_sync;

  // Observed debug outputs come from the cores on this clock: no sync needed
  function automatic logic [31:0] scdb_read(input scdb_state_type s,
                                            input logic [7:0] addr,
                                            input logic obs1,
                                            input logic obs0);
    logic [31:0] v;
    v = 32'h00000000;
    case (addr)
      SCDB_OFF_BYP_LO: v[SCDB_NUM_LO-1:0] = s.byp_lo;
      SCDB_OFF_BYP_HI: v[SCDB_NUM_HI-1:0] = s.byp_hi;
      SCDB_OFF_DBG: begin
        v[SCDB_DBG_C1_TAKE] = s.c1_take;
        v[SCDB_DBG_C1_CLK] = s.c1_clk;
        v[SCDB_DBG_C1_DAT] = s.c1_dat;
        v[SCDB_DBG_C1_OBS] = obs1;
        v[SCDB_DBG_C0_TAKE] = s.c0_take;
        v[SCDB_DBG_C0_CLK] = s.c0_clk;
        v[SCDB_DBG_C0_DAT] = s.c0_dat;
        v[SCDB_DBG_C0_OBS] = obs0;
      end
      SCDB_OFF_MEMPD: v[SCDB_NUM_MEM-1:0] = s.mempd;
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction : scdb_read

  // Bus slave: one wait cycle; a write lands at the completing edge
  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    if ((avm_req.read || avm_req.write) && !st_q.ack) begin
      st_d.ack = 1'b1;
      st_d.rdata = scdb_read(st_q, avm_req.address, core1_swdo, core0_swdo);
      if (avm_req.write) begin
        st_d.rdata = 32'h00000000;
      end
    end
    if (avm_req.write && st_q.ack) begin
      begin
        case (avm_req.address)
          SCDB_OFF_BYP_LO: st_d.byp_lo = avm_req.writedata[SCDB_NUM_LO-1:0];
          SCDB_OFF_BYP_HI: st_d.byp_hi = avm_req.writedata[SCDB_NUM_HI-1:0];
          SCDB_OFF_DBG: begin
            st_d.c1_take = avm_req.writedata[SCDB_DBG_C1_TAKE];
            st_d.c1_clk = avm_req.writedata[SCDB_DBG_C1_CLK];
            st_d.c1_dat = avm_req.writedata[SCDB_DBG_C1_DAT];
            st_d.c0_take = avm_req.writedata[SCDB_DBG_C0_TAKE];
            st_d.c0_clk = avm_req.writedata[SCDB_DBG_C0_CLK];
            st_d.c0_dat = avm_req.writedata[SCDB_DBG_C0_DAT];
          end
          SCDB_OFF_MEMPD: st_d.mempd = avm_req.writedata[SCDB_NUM_MEM-1:0];
          default: st_d.ack = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q.byp_lo <= SCDB_RST_BYP_LO;
      st_q.byp_hi <= SCDB_RST_BYP_HI;
      st_q.c1_take <= SCDB_RST_TAKE;
      st_q.c1_clk <= SCDB_RST_DRIVE;
      st_q.c1_dat <= SCDB_RST_DRIVE;
      st_q.c0_take <= SCDB_RST_TAKE;
      st_q.c0_clk <= SCDB_RST_DRIVE;
      st_q.c0_dat <= SCDB_RST_DRIVE;
      st_q.mempd <= SCDB_RST_MEMPD;
      st_q.ack <= 1'b0;
      st_q.rdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    avm_rsp.waitrequest = (avm_req.read || avm_req.write) && !st_q.ack;
    avm_rsp.readdata = st_q.rdata;
  end

  scdb_sync2 #(
    .WIDTH(SCDB_NUM_LO)
  ) u_sync_lo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(gpio_lo_pad_in),
    .bypass(st_q.byp_lo),
    .sync_out(lo_sync)
  );

  scdb_sync2 #(
    .WIDTH(SCDB_NUM_HI)
  ) u_sync_hi (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(gpio_hi_pad_in),
    .bypass(st_q.byp_hi),
    .sync_out(hi_sync)
  );

  // Bypassed bits skip both stages of the synchroniser
  always_comb begin
    gpio_lo_to_sio = lo_sync;
    gpio_hi_to_sio = hi_sync;
  end

  // Debug source selection; pads win while detached
  always_comb begin
    if (st_q.c1_take) begin
      core1_dbg.swclk = st_q.c1_clk;
      core1_dbg.swdi = st_q.c1_dat;
    end else begin
      core1_dbg = core1_pad_dbg;
    end
    if (st_q.c0_take) begin
      core0_dbg.swclk = st_q.c0_clk;
      core0_dbg.swdi = st_q.c0_dat;
    end else begin
      core0_dbg = core0_pad_dbg;
    end
  end

  always_comb begin
    memory_power_down = st_q.mempd;
  end

  a_core1_take_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q.c1_take |-> (core1_dbg.swclk == st_q.c1_clk && core1_dbg.swdi == st_q.c1_dat))
    else $error("core 1 debug not driven by register");

  a_core0_take_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q.c0_take |-> (core0_dbg.swclk == st_q.c0_clk && core0_dbg.swdi == st_q.c0_dat))
    else $error("core 0 debug not driven by register");

  a_detached_pads: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!st_q.c1_take |-> core1_dbg == core1_pad_dbg) and
    (!st_q.c0_take |-> core0_dbg == core0_pad_dbg))
    else $error("detached core not fed from pads");

  a_dbg_write_lands: assert property (@(posedge clk_sys) disable iff (!resetn)
    (avm_req.write && !avm_rsp.waitrequest && avm_req.address == SCDB_OFF_DBG)
    |=> (st_q.c1_clk == $past(avm_req.writedata[SCDB_DBG_C1_CLK])
         && st_q.c0_dat == $past(avm_req.writedata[SCDB_DBG_C0_DAT])))
    else $error("debug override write lost");

  a_obs_read_back: assert property (@(posedge clk_sys) disable iff (!resetn)
    (avm_req.read && avm_rsp.waitrequest && avm_req.address == SCDB_OFF_DBG)
    |=> (avm_rsp.readdata[SCDB_DBG_C1_OBS] == $past(core1_swdo)
         && avm_rsp.readdata[SCDB_DBG_C0_OBS] == $past(core0_swdo)))
    else $error("observed debug output wrong on read");

  a_mempd_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    (avm_req.write && !avm_rsp.waitrequest && avm_req.address == SCDB_OFF_MEMPD)
    |=> memory_power_down == $past(avm_req.writedata[SCDB_NUM_MEM-1:0]))
    else $error("power-down write not applied");

  a_bypass_lo_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    (avm_req.write && !avm_rsp.waitrequest && avm_req.address == SCDB_OFF_BYP_LO)
    |=> st_q.byp_lo == $past(avm_req.writedata[SCDB_NUM_LO-1:0]))
    else $error("low bypass write not applied");

  a_bypass_hi_path: assert property (@(posedge clk_sys) disable iff (!resetn)
    (gpio_hi_to_sio & st_q.byp_hi) == (gpio_hi_pad_in & st_q.byp_hi))
    else $error("high bypass not direct");

  a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($rose(avm_req.read) || $rose(avm_req.write)) |-> avm_rsp.waitrequest ##1 !avm_rsp.waitrequest)
    else $error("bus answer not after one wait cycle");

endmodule : scdb_sysconfig

// >>> scdb_core_model.sv
// Model of the two cores' debug ports: each returns its debug data input
// one system clock later on its data output. Assumes both cores run on clk_sys.
module scdb_core_model
  import scdb_pkg::*;
(
  input wire logic clk_sys,
  input wire scdb_dbg_drive_type core0_dbg,
  input wire scdb_dbg_drive_type core1_dbg,
  output logic core0_swdo,
  output logic core1_swdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial core0_swdo = 1'b0;
  initial core1_swdo = 1'b0;
  always @(posedge clk_sys) begin
    core0_swdo <= core0_dbg.swdi;
    core1_swdo <= core1_dbg.swdi;
  end
endmodule : scdb_core_model

// >>> tb_top.sv
// Self-checking bench for the system configuration bank.
// Assumes the bank answers each Avalon access after one wait cycle.
module tb_top;
  import scdb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  scdb_avm_req_type req = '0;
  scdb_avm_rsp_type rsp;
  logic [29:0] lo_pad = '0, lo_out;
  logic [5:0] hi_pad = '0, hi_out;
  scdb_dbg_drive_type p0 = '0, p1 = '0, c0, c1;
  logic swdo0, swdo1;
  logic [7:0] mem_pd;
  logic [31:0] rnd = 32'h3e, q, r;
  int err_count = 0, n_tests = 0;
  int m_dbg = 32'h66;
  logic [1:0] e0, e1;
  logic [29:0] lo_prev = '0;
  logic [5:0] hi_prev = '0;

  scdb_sysconfig i_scdb_sysconfig (.clk_sys(clk_sys), .resetn(resetn), .avm_req(req),
    .avm_rsp(rsp), .gpio_lo_pad_in(lo_pad), .gpio_hi_pad_in(hi_pad), .gpio_lo_to_sio(lo_out),
    .gpio_hi_to_sio(hi_out), .core0_pad_dbg(p0), .core1_pad_dbg(p1), .core0_dbg(c0),
    .core1_dbg(c1), .core0_swdo(swdo0), .core1_swdo(swdo1), .memory_power_down(mem_pd));
  scdb_core_model i_scdb_core_model (.clk_sys(clk_sys), .core0_dbg(c0), .core1_dbg(c1),
    .core0_swdo(swdo0), .core1_swdo(swdo1));

  always #5 clk_sys = ~clk_sys;

  function automatic logic [31:0] nxt();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction : nxt

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon access; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    @(posedge clk_sys);
    while (rsp.waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = rsp.readdata;
    req <= '0;
  endtask : bus

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    bus(0, 8'h0c, 0, q); chk("bypass_low reset", q, 0);
    bus(0, 8'h10, 0, q); chk("bypass_high reset", q, 0);
    bus(0, 8'h14, 0, q); chk("override reset", q, 32'h66);
    bus(0, 8'h18, 0, q); chk("power_down reset", q, 0);
    bus(0, 8'h00, 0, q); chk("unmapped read", q, 0);
    chk("power_down pins reset", mem_pd, 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = nxt();
      bus(1, 8'h18, r, q);
      bus(1, 8'h00, ~r, q);
      #1 chk("power_down pins", mem_pd, r[7:0]);
      bus(0, 8'h18, 0, q); chk("power_down read", q, r & 32'hff);
      bus(1, 8'h0c, r, q);
      bus(0, 8'h0c, 0, q); chk("bypass_low read", q, r & 32'h3fffffff);
      bus(1, 8'h10, ~r, q);
      bus(0, 8'h10, 0, q); chk("bypass_high read", q, ~r & 32'h3f);
      q = nxt();
      @(posedge clk_sys);
      lo_pad <= q[29:0];
      hi_pad <= q[31:26];
      for (int j = 0; j < 3; j++) begin
        if (j > 0) @(posedge clk_sys);
        #1 chk("gpio low", lo_out, j < 2 ? (q[29:0] & r[29:0]) | (lo_prev & ~r[29:0]) : q[29:0]);
        chk("gpio high", hi_out, j < 2 ? (q[31:26] & ~r[5:0]) | (hi_prev & r[5:0]) : q[31:26]);
      end
      hi_prev = q[31:26];
      lo_prev = q[29:0];
    end
    bus(1, 8'h0c, 0, q);
    bus(1, 8'h10, 0, q);
    bus(1, 8'h18, 0, q);
    $display("test power and gpio done");
    for (int i = 0; i < 16; i++) begin
      r = nxt();
      r[7] = i[1];
      r[3] = i[0];
      p0 <= r[9:8];
      p1 <= r[11:10];
      bus(1, 8'h14, r, q);
      m_dbg = r & 32'hee;
      e0 = r[3] ? r[2:1] : r[9:8];
      e1 = r[7] ? r[6:5] : r[11:10];
      #1 chk("core0 debug", c0, e0);
      chk("core1 debug", c1, e1);
      bus(0, 8'h14, 0, q);
      chk("override read", q, m_dbg | {e1[0], 3'h0, e0[0]});
    end
    $display("test debug done");
    end_sim();
  end

  initial begin
    repeat (4000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end
endmodule : tb_top
